// *** fbp_checker.sv ***
// Port assertions for flash protection
`timescale 1ns/1ps
`default_nettype none
module fbp_checker
    import fbp_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic rst_n,
    input wire fbp_level_t [FBP_NUM_REGIONS-1:0] prot_level,
    input wire fbp_rd_req_t rd_req,
    input wire fbp_rd_rsp_t rd_rsp,
    input wire fbp_wr_req_t wr_req,
    input wire logic wr_ready,
    input wire logic busy,
    input wire logic viol_flag,
    input wire logic viol_clear
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rv = rd_req.valid;
    wire wt = wr_req.valid && wr_ready;
    wire wp = prot_level[wr_req.addr[12:11]] != FBP_PROT_NONE;
    wire xo = prot_level[rd_req.addr[12:11]] == FBP_PROT_XO;
    wire dn = rv && xo && rd_req.src != FBP_OP_FETCH;
    a_rsp_next: assert property (rv |=> rd_rsp.valid)
        else $error("rsp");
    a_busy_ready: assert property (busy |-> !wr_ready)
        else $error("rdy");
    a_xo_deny: assert property (dn |=> rd_rsp.denied && rd_rsp.data == 0)
        else $error("deny");
    a_read_ok: assert property (rv && !dn |=> !rd_rsp.denied)
        else $error("read");
    a_erase_run: assert property (wt && wr_req.erase && !wp |=> busy[*8])
        else $error("erase");
    a_prot_hold: assert property (wt && wp |=> !busy && viol_flag)
        else $error("prot");
    a_viol_keep: assert property (viol_flag && !viol_clear |=> viol_flag)
        else $error("keep");
    a_viol_clr: assert property
        (viol_clear && !(wt && wp) && !dn |=> !viol_flag)
        else $error("clr");
endmodule
bind fbp_flash_protect fbp_checker chk (.mclk(mclk), .rst_n(rst_n),
    .prot_level(prot_level), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .wr_req(wr_req), .wr_ready(wr_ready), .busy(busy),
    .viol_flag(viol_flag), .viol_clear(viol_clear));
`default_nettype wire

// *** fbp_flash_protect.sv ***
// Flash array with block erase and per-region protection
// How it works
// [R1] 8 KB array, eight 1 KB erasable blocks
// [R2] Erase writes all ones into block
// [R3] Protection per 2 KB block pair
// [R4] Levels: none, read-only, execute-only
// [R5] Read-only: erase and program refused
// [R6] Execute-only: erase and program refused
// [R7] Execute-only: fetch reads only
// [R8] Refusal sets sticky violation flag
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_protect
    import fbp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Protection level per region
    input wire fbp_level_t [FBP_NUM_REGIONS-1:0] prot_level,
    // Read path
    input wire fbp_rd_req_t rd_req,
    output fbp_rd_rsp_t rd_rsp,
    // Erase and program path
    input wire fbp_wr_req_t wr_req,
    output logic wr_ready,
    // Status
    output logic busy,
    output logic viol_flag,
    input wire logic viol_clear
);
    logic [31:0] mem [FBP_WORDS];
    fbp_regs_t r_q;
    fbp_regs_t r_d;

    // Region index of a byte address
    function automatic logic [FBP_REG_W-1:0] region_of(
        input logic [FBP_ADDR_W-1:0] a);
        region_of = a[FBP_ADDR_W-1:FBP_REG_LSB];
    endfunction

    logic wr_ok;
    logic wr_take;
    logic rd_ok;
    logic prog_we;
    logic [FBP_WADDR_W-1:0] wr_widx;
    logic [FBP_WADDR_W-1:0] erase_widx;
    fbp_level_t wlev;
    fbp_level_t rlev;

    assign wr_ready = (r_q.st == FBP_ST_IDLE);
    assign wr_take = wr_req.valid && wr_ready;
    // [R4] Level per region
    assign wlev = prot_level[region_of(wr_req.addr)];
    assign rlev = prot_level[region_of(rd_req.addr)];
    // [R5] [R6] Writes refused
    assign wr_ok = (wlev == FBP_PROT_NONE);
    // [R7] Fetch-only read
    assign rd_ok = (rlev != FBP_PROT_XO) || (rd_req.src == FBP_OP_FETCH);
    assign prog_we = wr_take && wr_ok && !wr_req.erase;
    assign wr_widx = wr_req.addr[FBP_ADDR_W-1:2];
    assign erase_widx = {r_q.eblk, r_q.ecnt[7:0]};

    always_comb begin
        r_d = r_q;
        r_d.rsp.valid = rd_req.valid;
        r_d.rsp.denied = rd_req.valid && !rd_ok;
        if (rd_req.valid && rd_ok) begin
            r_d.rsp.data = mem[rd_req.addr[FBP_ADDR_W-1:2]];
        end else begin
            r_d.rsp.data = FBP_RDATA_RST;
        end
        case (r_q.st)
            FBP_ST_IDLE: begin
                if (wr_take && wr_ok && wr_req.erase) begin
                    // [R1] Start one-block erase
                    r_d.st = FBP_ST_ERASE;
                    r_d.eblk = wr_req.addr[FBP_ADDR_W-1:FBP_BLK_LSB];
                    r_d.ecnt = {wr_req.addr[FBP_ADDR_W-1:FBP_BLK_LSB],
                                8'h00};
                end
            end
            FBP_ST_ERASE: begin
                if (r_q.ecnt[7:0] == 8'hff) begin
                    r_d.st = FBP_ST_IDLE;
                end
                r_d.ecnt = r_q.ecnt + 11'h001;
            end
            default: r_d.st = FBP_ST_IDLE;
        endcase
        r_d.busy = (r_d.st == FBP_ST_ERASE);
        // [R8] Set wins over clear
        if ((wr_take && !wr_ok) || (rd_req.valid && !rd_ok)) begin
            r_d.viol = 1'b1;
        end else if (viol_clear) begin
            r_d.viol = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '{st: FBP_ST_IDLE, eblk: FBP_ECNT_RST, ecnt: '0,
                     rsp: '0, viol: 1'b0, busy: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // Array storage; erase and program never overlap
    always_ff @(posedge mclk) begin
        if (r_q.st == FBP_ST_ERASE) begin
            // [R2] Erase to ones
            mem[erase_widx] <= FBP_ERASED_WORD;
        end else if (prog_we) begin
            // Programming only clears bits
            mem[wr_widx] <= mem[wr_widx] & wr_req.wdata;
        end
    end

    // [R3] Regions decoded by region_of
    assign rd_rsp = r_q.rsp;
    assign busy = r_q.busy;
    assign viol_flag = r_q.viol;
endmodule
`default_nettype wire

// *** fbp_host.sv ***
// Processor and debugger request model
`timescale 1ns/1ps
`default_nettype none
module fbp_host
    import fbp_pkg::*;
(
    // Clock and requests
    input wire logic mclk,
    output var fbp_rd_req_t rd_req,
    output var fbp_wr_req_t wr_req
);
    initial {rd_req, wr_req} = '0;
    // Released fields show inverted values, except the read source, which is held
    task automatic rd(fbp_rd_src_t s, logic [12:0] a);
        @(posedge mclk) rd_req <= '{1'b1, s, a};
        @(posedge mclk) rd_req <= '{1'b0, s, ~a};
        #1;
    endtask
    task automatic wr(logic e, logic [12:0] a, logic [31:0] d);
        @(posedge mclk) wr_req <= '{1'b1, e, a, d};
        @(posedge mclk) wr_req <= '{1'b0, ~e, ~a, ~d};
        #1;
    endtask
endmodule
`default_nettype wire

// *** fbp_pkg.sv ***
// Package for flash block protection: geometry, levels and port structs
package fbp_pkg;
    localparam int FBP_ARRAY_BYTES = 8192;
    localparam int FBP_BLOCK_BYTES = 1024;
    localparam int FBP_REGION_BYTES = 2048;
    localparam int FBP_WORD_BYTES = 4;
    localparam int FBP_NUM_BLOCKS = FBP_ARRAY_BYTES / FBP_BLOCK_BYTES;
    localparam int FBP_NUM_REGIONS = FBP_ARRAY_BYTES / FBP_REGION_BYTES;
    localparam int FBP_WORDS = FBP_ARRAY_BYTES / FBP_WORD_BYTES;
    localparam int FBP_BLOCK_WORDS = FBP_BLOCK_BYTES / FBP_WORD_BYTES;
    localparam int FBP_ADDR_W = 13;
    localparam int FBP_WADDR_W = 11;
    localparam int FBP_BLK_LSB = 10;
    localparam int FBP_REG_LSB = 11;
    localparam int FBP_BLK_W = 3;
    localparam int FBP_REG_W = 2;
    localparam logic [31:0] FBP_ERASED_WORD = 32'hffffffff;
    localparam logic [31:0] FBP_RDATA_RST = 32'h00000000;
    localparam logic [FBP_BLK_W-1:0] FBP_ECNT_RST = 3'h0;

    typedef enum logic [1:0] {
        FBP_PROT_NONE,
        FBP_PROT_RO,
        FBP_PROT_XO
    } fbp_level_t;

    typedef enum logic [1:0] {
        FBP_OP_FETCH,
        FBP_OP_DREAD,
        FBP_OP_DBG
    } fbp_rd_src_t;

    typedef struct packed {
        logic valid;
        fbp_rd_src_t src;
        logic [FBP_ADDR_W-1:0] addr;
    } fbp_rd_req_t;

    typedef struct packed {
        logic valid;
        logic erase;
        logic [FBP_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } fbp_wr_req_t;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [31:0] data;
    } fbp_rd_rsp_t;

    typedef enum logic [0:0] {
        FBP_ST_IDLE,
        FBP_ST_ERASE
    } fbp_state_t;

    typedef struct packed {
        fbp_state_t st;
        logic [FBP_BLK_W-1:0] eblk;
        logic [FBP_WADDR_W-1:0] ecnt;
        fbp_rd_rsp_t rsp;
        logic viol;
        logic busy;
    } fbp_regs_t;
endpackage

// *** testbench.sv ***
// Flash protection bench
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) bad(); end
module testbench;
    import fbp_pkg::*;
    logic mclk = 0;
    logic rst_n = 0;
    logic viol_clear = 0;
    fbp_level_t [FBP_NUM_REGIONS-1:0] prot_level = '{default: FBP_PROT_NONE};
    fbp_rd_req_t rd_req;
    fbp_wr_req_t wr_req;
    fbp_rd_rsp_t rd_rsp;
    logic wr_ready, busy, viol_flag;
    int err_total = 0;
    int n_checks = 0;
    fbp_host host (.*);
    fbp_flash_protect uut (.*);
    always #12.5 mclk = ~mclk;
    task automatic bad();
        err_total++;
        $display("Error %0t mismatch", $time);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rd(fbp_rd_src_t s, logic [12:0] a, logic [32:0] e);
        host.rd(s, a);
        `CK({rd_rsp.valid, rd_rsp.denied, rd_rsp.data}, {1'b1, e})
    endtask
    task automatic t_erase();
        host.wr(1, 13'h0400, 0);
        `CK({busy, wr_ready}, 2'b10)
        repeat (256) @(posedge mclk);
        #1 `CK({busy, wr_ready}, 2'b01)
        rd(FBP_OP_DREAD, 13'h07fc, {1'b0, FBP_ERASED_WORD});
        host.wr(0, 13'h0404, 32'h0000a5a5);
        rd(FBP_OP_DBG, 13'h0404, 33'h0000a5a5);
    endtask
    task automatic t_ro();
        @(posedge mclk) prot_level[0] <= FBP_PROT_RO;
        host.wr(1, 13'h0400, 0);
        `CK({busy, viol_flag}, 2'b01)
        rd(FBP_OP_DBG, 13'h0404, 33'h0000a5a5);
    endtask
    task automatic t_xo();
        @(posedge mclk) viol_clear <= 1;
        @(posedge mclk) prot_level[0] <= FBP_PROT_XO;
        viol_clear <= 0;
        #1 `CK(viol_flag, 1'b0)
        host.wr(0, 13'h0404, 0);
        `CK({busy, viol_flag}, 2'b01)
        rd(FBP_OP_FETCH, 13'h0404, 33'h0000a5a5);
        rd(FBP_OP_DREAD, 13'h0404, 33'h100000000);
        rd(FBP_OP_DBG, 13'h0404, 33'h100000000);
        host.wr(1, 13'h0800, 0);
        `CK(busy, 1'b1)
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        `CK({busy, viol_flag, rd_rsp.valid, wr_ready}, 4'b0001)
        rst_n <= 1;
        t_erase();
        t_ro();
        t_xo();
        summarize();
    end
    initial begin
        #40000;
        bad();
        summarize();
    end
endmodule
`default_nettype wire
